// ===== hw/wma_pkg.sv
// Package: constants, register map and carrier types of the slot allocator
package wma_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_RES      = 8'h04;
    localparam logic [7:0] REG_SLOT     = 8'h08;
    localparam logic [7:0] REG_ACQ      = 8'h0C;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_STACK0   = 8'h20;
    localparam logic [7:0] REG_ZREF0    = 8'h40;
    localparam logic [7:0] REG_VSCALE0  = 8'h60;
    localparam logic [7:0] REG_HSCALE0  = 8'h80;
    localparam logic [7:0] REG_PADDR    = 8'hA0;
    localparam logic [7:0] REG_PDATA    = 8'hA4;
    // Geometry: fixed store, 2048 points base, 5120 extended
    localparam int STACK_DEPTH  = 5;
    localparam int MAX_SLOTS    = 40;
    localparam int STORE_BASE   = 2048;
    localparam int STORE_EXT    = 5120;
    localparam int STORE_WORDS  = 64;
    // Resolution codes and values
    localparam logic [1:0] RES_128  = 2'h0;
    localparam logic [1:0] RES_256  = 2'h1;
    localparam logic [1:0] RES_512  = 2'h2;
    localparam logic [1:0] RES_1024 = 2'h3;
    localparam logic [10:0] PTS_128  = 11'h080;
    localparam logic [10:0] PTS_256  = 11'h100;
    localparam logic [10:0] PTS_512  = 11'h200;
    localparam logic [10:0] PTS_1024 = 11'h400;
    localparam logic [1:0] RES_RESET = RES_512;
    // Build variants
    localparam logic [1:0] BUILD_BASE    = 2'h0;
    localparam logic [1:0] BUILD_EXT     = 2'h1;
    localparam logic [1:0] BUILD_REDUCED = 2'h2;
    // Point quantisation: 1024 levels over 10 divisions, 102.4 per div
    localparam int LEVEL_BITS = 10;
    // Header defaults: one volt, one second, zero reference zero
    localparam logic [15:0] SCALE_ONE  = 16'h0001;
    localparam logic [15:0] ZREF_RESET = 16'h0000;
    // Control bits
    localparam int CTRL_SET_RES  = 0;
    localparam int CTRL_RECALL   = 1;
    localparam int CTRL_ACQUIRE  = 2;
    localparam int CTRL_AVERAGE  = 3;
    localparam int CTRL_CLR_ERR  = 4;
    // Status bits
    localparam int ST_SLOT_ERR   = 0;
    localparam int ST_ACQ_ERR    = 1;
    localparam int ST_RES_ERR    = 2;
    localparam int ST_TIME_DISP  = 3;
    localparam int ST_CLR_DISP   = 4;
    // Display modes
    typedef enum logic [2:0] {
        WMA_MODE_SINGLE  = 3'h0,
        WMA_MODE_VALT    = 3'h1,
        WMA_MODE_UNITALT = 3'h2,
        WMA_MODE_SUMALT  = 3'h3,
        WMA_MODE_HALT    = 3'h4
    } wma_mode_t;
    // Acquisition setup as software writes it
    typedef struct packed {
        logic [2:0] waveCount;
        logic       chopPlugin;
        wma_mode_t  mode;
    } wma_acq_t;
    // Acquisition sample from the front end
    typedef struct packed {
        logic                  valid;
        logic                  second;
        logic [LEVEL_BITS-1:0] level;
        logic [15:0]           vScale;
        logic [15:0]           hScale;
        logic                  scaleValid;
    } wma_sample_t;
    // Allocator states, one-hot
    typedef enum logic [3:0] {
        WMA_IDLE  = 4'b0001,
        WMA_ACQ   = 4'b0010,
        WMA_AVG   = 4'b0100,
        WMA_DONE  = 4'b1000
    } wma_state_t;
endpackage

// ===== hw/wma_top.sv
// Waveform slot allocator: resolution, slots, routing and power-up contents
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module wma_top
    import wma_pkg::*;
#(
    parameter logic [1:0] BUILD = BUILD_BASE
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire wma_sample_t sampleIn,
    output logic             acqBusy,
    output logic             timeDisplayCmd,
    output logic             clearDisplayCmd
);
    logic [1:0]             resFf;
    logic [1:0]             nxtRes;
    logic [5:0]             slotIndexFf;
    logic [31:0]            stackFf [STACK_DEPTH];
    logic [15:0]            zrefFf [MAX_SLOTS];
    logic [15:0]            vScaleFf [MAX_SLOTS];
    logic [15:0]            hScaleFf [MAX_SLOTS];
    logic [LEVEL_BITS-1:0]  pointFf [STORE_WORDS];
    logic [12:0]            pAddrFf;
    wma_acq_t               acqFf;
    logic [4:0]             statusFf;
    wma_state_t             stateFf;
    logic [10:0]            ptrFf;
    logic [5:0]             slotCount;
    logic [10:0]            pointsPer;
    logic                   apbAcc;
    logic                   wrCtrl;
    logic                   setResReq;
    logic                   resOk;
    logic                   resChange;
    logic                   recallReq;
    logic                   recallBad;
    logic                   acqReq;
    logic                   avgReq;
    logic                   acqBad;
    logic [5:0]             tgtSlot;
    logic [5:0]             hdrSlot;
    logic [12:0]            wrAddr;
    logic                   smpWr;

    // Slot count and points from resolution and build
    // A new resolution regroups the same fixed store;
    // no stored point is moved or cleared by it
    always_comb begin
        case (resFf)
            RES_128:  pointsPer = PTS_128;
            RES_256:  pointsPer = PTS_256;
            RES_512:  pointsPer = PTS_512;
            default:  pointsPer = PTS_1024;
        endcase
        if (BUILD == BUILD_REDUCED) begin
            slotCount = 6'd2;
        end else if (BUILD == BUILD_EXT) begin
            slotCount = 6'(STORE_EXT / int'(pointsPer));
        end else begin
            slotCount = 6'(STORE_BASE / int'(pointsPer));
        end
    end

    // APB decode of one-cycle accesses
    // Strobes count only in the access phase, so a
    // long setup cycle cannot repeat a command
    assign apbAcc    = psel & penable;
    assign wrCtrl    = apbAcc & pwrite & (paddr == REG_CTRL);
    assign setResReq = wrCtrl & pwdata[CTRL_SET_RES];
    assign recallReq = wrCtrl & pwdata[CTRL_RECALL];
    assign acqReq    = wrCtrl & pwdata[CTRL_ACQUIRE] & (stateFf == WMA_IDLE);
    assign avgReq    = wrCtrl & pwdata[CTRL_AVERAGE] & (stateFf == WMA_IDLE);
    // Requested resolution held in bits 9:8 of CTRL register write data
    assign nxtRes    = pwdata[9:8];
    assign resOk     = (BUILD != BUILD_REDUCED) & (pwdata[15:10] == 6'h00);
    assign resChange = setResReq & resOk & (nxtRes != resFf);
    assign recallBad = recallReq & (pwdata[21:16] >= slotCount);
    // Averaging needs exactly one waveform; acquiring at most two, no chop
    assign acqBad    = (acqReq & ((acqFf.waveCount > 3'd2)
                        | acqFf.chopPlugin))
                     | (avgReq & (acqFf.waveCount != 3'd1));

    // Resolution register
    // Rewriting the current code is no change, so the
    // display and the stack are left alone then
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resFf <= RES_RESET;
        end else if (resChange) begin
            resFf <= nxtRes;
        end
    end

    // Displayed slot index
    // A recall beyond the slot range is refused and
    // the index keeps its old value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slotIndexFf <= 6'h00;
        end else if (resChange) begin
            slotIndexFf <= 6'h00;
        end else if (recallReq & ~recallBad) begin
            slotIndexFf <= pwdata[21:16];
        end
    end

    // Operand stack
    // Wiped on each resolution change and not brought
    // back when the old resolution returns
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stackFf[i] <= 32'h00000000;
            end
        end else if (resChange) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stackFf[i] <= 32'h00000000;
            end
        end else if (apbAcc & pwrite & (paddr >= REG_STACK0)
                     & (paddr < REG_STACK0 + 8'h14)) begin
            stackFf[3'(paddr[4:2])] <= pwdata;
        end
    end

    // Implicit display commands, one-cycle pulses
    // Both fire in the same cycle so the display side
    // always sees them as one pair
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timeDisplayCmd  <= 1'b0;
            clearDisplayCmd <= 1'b0;
        end else begin
            timeDisplayCmd  <= resChange;
            clearDisplayCmd <= resChange;
        end
    end

    // Acquisition setup register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acqFf <= '0;
        end else if (apbAcc & pwrite & (paddr == REG_ACQ)) begin
            acqFf <= wma_acq_t'(pwdata[6:0]);
        end
    end

    // Sequencer for acquisition and averaging
    // There is no abort: a run waits for the last
    // sample of its last component
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateFf <= WMA_IDLE;
        end else begin
            case (stateFf)
                WMA_IDLE: begin
                    if (acqReq & ~acqBad) begin
                        stateFf <= WMA_ACQ;
                    end else if (avgReq & ~acqBad) begin
                        stateFf <= WMA_AVG;
                    end
                end
                WMA_ACQ, WMA_AVG: begin
                    if (smpWr & (ptrFf == pointsPer - 11'd1)
                        & (sampleIn.second | (acqFf.waveCount < 3'd2)
                           | (stateFf == WMA_AVG))) begin
                        stateFf <= WMA_DONE;
                    end
                end
                WMA_DONE: stateFf <= WMA_IDLE;
                default:  stateFf <= WMA_IDLE;
            endcase
        end
    end

    // Target slot for each incoming component
    // Averaging writes slot one only, wiping whatever
    // the operator had kept there
    always_comb begin
        tgtSlot = 6'h00;
        if (stateFf == WMA_AVG) begin
            tgtSlot = 6'h01;
        end else if (acqFf.waveCount == 3'd2) begin
            // Second component of every dual mode lands in slot one
            case (acqFf.mode)
                WMA_MODE_VALT:    tgtSlot = {5'h00, sampleIn.second};
                WMA_MODE_UNITALT: tgtSlot = {5'h00, sampleIn.second};
                WMA_MODE_SUMALT:  tgtSlot = {5'h00, sampleIn.second};
                WMA_MODE_HALT:    tgtSlot = {5'h00, sampleIn.second};
                default:          tgtSlot = 6'h00;
            endcase
        end
    end

    assign smpWr  = sampleIn.valid
                  & ((stateFf == WMA_ACQ) | (stateFf == WMA_AVG));
    assign wrAddr = 13'(int'(tgtSlot) * int'(pointsPer) + int'(ptrFf));
    assign hdrSlot = tgtSlot;

    // Point pointer, advances after the last component of each point
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ptrFf <= 11'h000;
        end else if (stateFf == WMA_IDLE) begin
            ptrFf <= 11'h000;
        end else if (smpWr & (sampleIn.second
                     | (acqFf.waveCount < 3'd2) | (stateFf == WMA_AVG))) begin
            ptrFf <= ptrFf + 11'd1;
        end
    end

    // Point store window; raw points survive a resolution change
    // Only a window is modelled; writes that fall
    // beyond it are dropped without an error
    generate
        for (genvar g = 0; g < STORE_WORDS; g++) begin : gPoint
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    pointFf[g] <= '0;
                end else if (smpWr & (wrAddr == 13'(g))) begin
                    pointFf[g] <= sampleIn.level;
                end else if (apbAcc & pwrite & (paddr == REG_PDATA)
                             & (pAddrFf == 13'(g))) begin
                    pointFf[g] <= pwdata[LEVEL_BITS-1:0];
                end
            end
        end
    endgenerate

    // Slot headers: zero reference and scale factors
    // Scales follow every sample that carries them;
    // software sets the zero reference of slots 0-7
    generate
        for (genvar s = 0; s < MAX_SLOTS; s++) begin : gHdr
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    zrefFf[s]   <= ZREF_RESET;
                    vScaleFf[s] <= SCALE_ONE;
                    hScaleFf[s] <= SCALE_ONE;
                end else if (smpWr & sampleIn.scaleValid
                             & (hdrSlot == 6'(s))) begin
                    vScaleFf[s] <= sampleIn.vScale;
                    hScaleFf[s] <= sampleIn.hScale;
                end else if (apbAcc & pwrite
                             & (paddr == REG_ZREF0 + 8'(s % 8) * 8'h04)
                             & (s < 8)) begin
                    zrefFf[s] <= pwdata[15:0];
                end
            end
        end
    endgenerate

    // Point address for software window access
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pAddrFf <= 13'h0000;
        end else if (apbAcc & pwrite & (paddr == REG_PADDR)) begin
            pAddrFf <= pwdata[12:0];
        end
    end

    // Sticky status; a new error wins over a clear
    // Display-done bits stay set until cleared, so a
    // change is seen after its pulses have passed
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            statusFf <= 5'h00;
        end else begin
            if (wrCtrl & pwdata[CTRL_CLR_ERR]) begin
                statusFf <= 5'h00;
            end
            if (recallBad) begin
                statusFf[ST_SLOT_ERR] <= 1'b1;
            end
            if (acqBad) begin
                statusFf[ST_ACQ_ERR] <= 1'b1;
            end
            if (setResReq & ~resOk) begin
                statusFf[ST_RES_ERR] <= 1'b1;
            end
            if (resChange) begin
                statusFf[ST_TIME_DISP] <= 1'b1;
                statusFf[ST_CLR_DISP]  <= 1'b1;
            end
        end
    end

    // Busy flag
    // Rises the cycle after a legal run request so the
    // front end starts feeding samples at once
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acqBusy <= 1'b0;
        end else begin
            acqBusy <= (stateFf == WMA_ACQ) | (stateFf == WMA_AVG)
                     | ((acqReq | avgReq) & ~acqBad);
        end
    end

    // APB read data and answer, zero wait state
    // Data is taken in the setup cycle and stands in
    // the single access cycle that carries the answer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel & ~penable & ~pwrite) begin
                case (paddr)
                    REG_RES:    prdata <= {16'h0000, 5'h00, pointsPer};
                    REG_SLOT:   prdata <= {10'h000, slotCount, 10'h000,
                                           slotIndexFf};
                    REG_ACQ:    prdata <= {25'h0000000, acqFf};
                    REG_STATUS: prdata <= {26'h0000000, acqBusy, statusFf};
                    REG_PADDR:  prdata <= {19'h00000, pAddrFf};
                    REG_PDATA:  prdata <= {22'h000000,
                                           pointFf[6'(pAddrFf[5:0])]};
                    default: begin
                        if (paddr >= REG_STACK0 && paddr < REG_STACK0 + 8'h14) begin
                            prdata <= stackFf[3'(paddr[4:2])];
                        end else if (paddr >= REG_ZREF0
                                     && paddr < REG_ZREF0 + 8'h20) begin
                            prdata <= {16'h0000, zrefFf[3'(paddr[4:2])]};
                        end else if (paddr >= REG_VSCALE0
                                     && paddr < REG_VSCALE0 + 8'h20) begin
                            prdata <= {16'h0000, vScaleFf[3'(paddr[4:2])]};
                        end else if (paddr >= REG_HSCALE0
                                     && paddr < REG_HSCALE0 + 8'h20) begin
                            prdata <= {16'h0000, hScaleFf[3'(paddr[4:2])]};
                        end else if (paddr != REG_CTRL) begin
                            pslverr <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// ===== bench/wma_properties.sv
// Checker of bus timing and display command pulses of the slot allocator
`timescale 1ns/1ps
module wma_checker
    import wma_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        acqBusy,
    input wire logic        timeDisplayCmd,
    input wire logic        clearDisplayCmd
);
    logic ctrlWr;
    logic resWr1_ff;
    logic resWr2_ff;
    logic runWr1_ff;
    logic runWr2_ff;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Control register write in its access phase
    assign ctrlWr = psel && penable && pwrite && paddr == REG_CTRL;
    // Delayed copies of resolution and run requests
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resWr1_ff <= 1'b0;
            resWr2_ff <= 1'b0;
            runWr1_ff <= 1'b0;
            runWr2_ff <= 1'b0;
        end else begin
            resWr1_ff <= ctrlWr && pwdata[CTRL_SET_RES];
            resWr2_ff <= resWr1_ff;
            runWr1_ff <= ctrlWr && (pwdata[CTRL_ACQUIRE] || pwdata[CTRL_AVERAGE]);
            runWr2_ff <= runWr1_ff;
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        psel && penable && pready;
    endsequence
    a_pready_timely: assert property (setup_s |=> answer_s)
        else $error("no answer right after setup");
    a_pready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_pready_phase: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_slverr_read: assert property (pslverr |-> pready && !pwrite)
        else $error("pslverr without read answer");
    a_time_cause: assert property (timeDisplayCmd |-> resWr1_ff || resWr2_ff)
        else $error("time display without resolution write");
    a_time_pulse: assert property (timeDisplayCmd |=> !timeDisplayCmd)
        else $error("time display pulse too long");
    a_clear_pair: assert property ($rose(clearDisplayCmd)
        |-> timeDisplayCmd ##1 !clearDisplayCmd)
        else $error("clear display not paired");
    a_clear_cause: assert property (clearDisplayCmd
        |-> resWr1_ff || resWr2_ff)
        else $error("clear display without resolution write");
    a_busy_cause: assert property ($rose(acqBusy)
        |-> runWr1_ff || runWr2_ff)
        else $error("busy without run request");
endmodule
bind wma_top wma_checker wma_checker_inst (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .acqBusy(acqBusy), .timeDisplayCmd(timeDisplayCmd),
    .clearDisplayCmd(clearDisplayCmd));

// ===== bench/wma_front_end.sv
// Model of the acquisition front end feeding samples while busy
`timescale 1ns/1ps
module wma_front_end
    import wma_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        acqBusy,
    input  wire logic        twoWave,
    input  wire logic [15:0] scaleBase,
    output wma_sample_t      sampleIn
);
    logic secondFlag_ff;
    // One sample every other cycle while busy, level scrambled between
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sampleIn <= '0;
            secondFlag_ff <= 1'b0;
        end else if (acqBusy && !sampleIn.valid) begin
            sampleIn.valid <= 1'b1;
            sampleIn.second <= secondFlag_ff;
            sampleIn.level <= sampleIn.level + 10'h0A5;
            sampleIn.vScale <= scaleBase + {15'h0, secondFlag_ff};
            sampleIn.hScale <= scaleBase + 16'h2 + {15'h0, secondFlag_ff};
            sampleIn.scaleValid <= 1'b1;
            secondFlag_ff <= twoWave && !secondFlag_ff;
        end else begin
            sampleIn.valid <= 1'b0;
            sampleIn.level <= ~sampleIn.level;
            sampleIn.scaleValid <= 1'b0;
            if (!acqBusy) secondFlag_ff <= 1'b0;
        end
    end
endmodule

// ===== bench/wma_top_bench.sv
// Self-checking bench of the slot allocator with a front end model
`timescale 1ns/1ps
module wma_top_bench;
    import wma_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    wma_sample_t sampleIn;
    logic        acqBusy;
    logic        timeDisplayCmd;
    logic        clearDisplayCmd;
    int          tdCount = 0;
    int          cdCount = 0;
    logic        twoWave = 1'b0;
    logic [15:0] scaleBase = 16'h0;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;
    always #25 clk_sys = ~clk_sys;
    wma_top wma_top_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sampleIn(sampleIn), .acqBusy(acqBusy),
        .timeDisplayCmd(timeDisplayCmd),
        .clearDisplayCmd(clearDisplayCmd));
    // Count implicit display command pulses
    always @(posedge clk_sys) begin
        tdCount <= tdCount + int'(timeDisplayCmd);
        cdCount <= cdCount + int'(clearDisplayCmd);
    end
    wma_front_end wma_front_end_inst (.clk_sys(clk_sys), .rst(rst),
        .acqBusy(acqBusy), .twoWave(twoWave), .scaleBase(scaleBase),
        .sampleIn(sampleIn));
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready wait", 32'h1, 32'(n));
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r & m);
    endtask
    // Start a run and wait for busy to rise and fall
    task automatic run(input logic [31:0] acq, input logic [31:0] cmd,
                       input logic [15:0] base);
        int n;
        twoWave <= acq[5];
        scaleBase <= base;
        wr(REG_ACQ, acq);
        wr(REG_CTRL, 32'h10);
        wr(REG_CTRL, cmd);
        n = 0;
        while (acqBusy !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            n++;
        end
        chk("busy rose", 32'h1, {31'h0, acqBusy});
        while (acqBusy !== 1'b0 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        rd(REG_STATUS, 32'h2, 32'h0, "acq err");
    endtask
    task automatic t_power_up;
        logic [31:0] r;
        logic e;
        rd(REG_RES, ALL, 32'h200, "res");
        rd(REG_SLOT, ALL, 32'h00040000, "slot");
        for (int i = 0; i < STACK_DEPTH; i++) begin
            rd(REG_STACK0 + 8'(4 * i), ALL, 32'h0, "stack");
        end
        rd(REG_ZREF0, ALL, {16'h0, ZREF_RESET}, "zref0");
        rd(REG_VSCALE0, ALL, {16'h0, SCALE_ONE}, "vscale0");
        rd(REG_HSCALE0, ALL, {16'h0, SCALE_ONE}, "hscale0");
        wr(REG_PADDR, 32'h0);
        rd(REG_PDATA, ALL, 32'h0, "point0");
        wr(8'hFC, 32'h1);
        apb(1'b0, 8'hFC, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("test power_up done");
    endtask
    task automatic t_resolution;
        logic [1:0] c;
        for (int k = 0; k < 4; k++) begin
            c = 2'(k ^ (k >> 1));
            wr(REG_CTRL, 32'h00010002);
            wr(REG_CTRL, 32'h10);
            wr(REG_CTRL, {22'h0, c, 8'h01});
            rd(REG_RES, ALL, 32'h80 << c, "res");
            rd(REG_SLOT, ALL, 32'(16 >> c) << 16, "slot");
            rd(REG_STATUS, 32'h18, 32'h18, "disp cmds");
        end
        wr(REG_CTRL, 32'h00040002);
        rd(REG_STATUS, 32'h1, 32'h1, "slot err");
        wr(REG_CTRL, 32'h00030002);
        rd(REG_SLOT, ALL, 32'h00040003, "slot idx");
        wr(REG_CTRL, 32'h10);
        wr(REG_CTRL, 32'h00000501);
        rd(REG_STATUS, 32'h1C, 32'h04, "res err");
        rd(REG_SLOT, ALL, 32'h00040003, "slot kept");
        chk("time pulses", 32'h4, 32'(tdCount));
        chk("clear pulses", 32'h4, 32'(cdCount));
        $display("test resolution done");
    endtask
    task automatic t_acquire;
        wr(REG_CTRL, {22'h0, RES_128, 8'h01});
        run(32'h10, 32'h4, 16'h0050);
        rd(REG_VSCALE0, ALL, 32'h50, "single");
        for (int m = 1; m < 5; m++) begin
            run(32'h20 | 32'(m), 32'h4, 16'(m * 16));
            rd(REG_VSCALE0, ALL, 32'(m * 16), "slot0");
            rd(REG_VSCALE0 + 8'h4, ALL, 32'(m * 16 + 1), "slot1");
            rd(REG_HSCALE0 + 8'h4, ALL, 32'(m * 16 + 3), "h1");
        end
        for (int b = 0; b < 2; b++) begin
            wr(REG_CTRL, 32'h10);
            wr(REG_ACQ, (b == 1) ? 32'h18 : 32'h30);
            wr(REG_CTRL, 32'h4);
            repeat (4) @(posedge clk_sys);
            chk("refused", 32'h0, {31'h0, acqBusy});
            rd(REG_STATUS, 32'h2, 32'h2, "acq err");
        end
        wr(REG_CTRL, {22'h0, RES_512, 8'h01});
        wr(REG_CTRL, {22'h0, RES_128, 8'h01});
        rd(REG_VSCALE0, ALL, 32'h40, "recovered");
        run(32'h10, 32'h8, 16'h0070);
        rd(REG_VSCALE0, ALL, 32'h40, "avg slot0");
        rd(REG_VSCALE0 + 8'h4, ALL, 32'h70, "avg slot1");
        $display("test acquire done");
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out;
        end
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        t_power_up;
        t_resolution;
        t_acquire;
        close_out;
    end
endmodule
